/* rtl/enc_mon_pkg.sv */
// package for the encoder alarm monitor: register map, field positions,
// thresholds and timing counts; assumes a 125 MHz bus clock
package enc_mon_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ctrl_off      = 8'h00; // encoder type select
   localparam logic [7:0] rotary_off    = 8'h04; // rotary mark spacing setting
   localparam logic [7:0] linear_off    = 8'h08; // linear mark spacing setting
   localparam logic [7:0] status_off    = 8'h0c; // alarm flags
   localparam logic [7:0] zm_count_off  = 8'h10; // increments since zero mark
   localparam logic [7:0] temp_off      = 8'h14; // last temperature sample readout (0.1 degc)
   localparam logic [7:0] serial_off    = 8'h18; // serial comm error word
   localparam logic [7:0] detail_off    = 8'h1c; // detailed internal alarm word
   localparam logic [7:0] plain_off     = 8'h20; // plain internal alarm word
   localparam logic [7:0] cd_off        = 8'h24; // track d/c level word

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [31:0] spacing_rst  = 32'h0000_0800; // default spacing
   localparam int          ctrl_linear_bit = 0;           // 1 = linear encoder
   localparam int          st_missing_bit  = 0;
   localparam int          st_overtemp_bit = 1;
   localparam int          st_serial_bit   = 2;
   localparam int          st_detail_bit   = 3;
   localparam int          st_plain_bit    = 4;
   localparam int          st_cd_bit       = 5;
   localparam int          st_cd_ok_bit    = 6;

   // serial error word bit positions
   localparam int se_alarm_bit   = 0;
   localparam int se_idle_bit    = 1;
   localparam int se_nostart_bit = 2;
   localparam int se_crc_bit     = 3;
   localparam int se_ack_bit     = 4;
   localparam int se_mode_bit    = 5;
   localparam int se_long_bit    = 8;
   localparam int se_ovf_bit     = 9;
   localparam int se_dbl_bit     = 10;
   localparam int se_parity_bit  = 11;
   localparam int se_mono_bit    = 12;

   // ----------------------------------------------------------------
   // thresholds
   // ----------------------------------------------------------------
   localparam logic [15:0] temp_limit    = 16'd1250;   // 125.0 degc in 0.1 units
   localparam int          frame_max_len = 64;         // longest permitted frame
   localparam int          cd_nom_mv     = 500;
   localparam int          cd_nom_code   = 32'h5333;   // 500 mV peak
   localparam int          cd_low_mv     = 230;
   localparam int          cd_high_mv    = 750;
   localparam logic [15:0] cd_low_code   = 16'((cd_low_mv * cd_nom_code) / cd_nom_mv);
   localparam logic [15:0] cd_high_code  = 16'((cd_high_mv * cd_nom_code) / cd_nom_mv);

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int clk_mhz          = 125;
   localparam int start_timeout_ms = 50;
   localparam int start_timeout_cyc = start_timeout_ms * 1000 * clk_mhz; // 6,250,000

endpackage

/* rtl/encoder_alarm_monitor.sv */
// encoder alarm monitor: zero-mark, temperature, serial protocol,
// internal alarm and track c/d level checks, readable over ahb-lite.
// assumes the front end hands over decoded strobes synchronous to hclk.
//
// Contract
// [RL1] missing-mark alarm beyond 1.5x spacing without mark
// [RL2] report increments since power-on or last mark
// [RL3] spacing from rotary or linear setting
// [RL4] overtemp fault above 125 degrees celsius
// [RL5] report temperature in tenths of degree
// [RL6] bit0 frame alarm, bit1 wrong idle
// [RL7] bit2 no start bit within 50 ms
// [RL8] bit3 checksum mismatch
// [RL9] bit4 request rejected, bit5 illegal mode
// [RL10] bit8 frame longer than 64 bits
// [RL11] bit9 buffer overflow, bit10 double-read error
// [RL12] bit11 parity, bit12 monoflop level error
// [RL13] detail word: page upper, causes lower
// [RL14] page zero causes bits 0 to 4
// [RL15] page one causes bits 0 to 7
// [RL16] plain alarm: bit0 fault, bit1 alarm
// [RL17] c/d word: d upper, c lower, signed
// [RL18] c/d alarm below 230 or above 750 mV
// [RL19] 500 mV peak equals 5333 hex
// [RL20] out-of-band c/d not used for start
// [RL21] distances in signed increments, four per pulse
// [RL22] clear spacing counter on mark, power-on
// [RL23] error bits held until firmware read; the detail word drops the old page's causes unread on a page change
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module encoder_alarm_monitor #(
   parameter int start_timeout_cyc = enc_mon_pkg::start_timeout_cyc
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // incremental tracks, one strobe per quadrature edge
   input  wire logic        inc_step,
   input  wire logic        inc_dir_neg,
   input  wire logic        zero_mark,
   // temperature sample in 0.1 degc
   input  wire logic        temp_valid,
   input  wire logic [15:0] temp_value,
   // serial protocol event strobes
   input  wire logic        ser_request,
   input  wire logic        ser_start_bit,
   input  wire logic        ser_frame_alarm,
   input  wire logic        ser_frame_fault,
   input  wire logic        ser_idle_err,
   input  wire logic        ser_crc_err,
   input  wire logic        ser_ack_err,
   input  wire logic        ser_mode_err,
   input  wire logic        ser_bit_strobe,
   input  wire logic        ser_frame_end,
   input  wire logic        ser_ovf_err,
   input  wire logic        ser_dbl_err,
   input  wire logic        ser_parity_err,
   input  wire logic        ser_mono_err,
   // encoder internal fault word
   input  wire logic        enc_word_valid,
   input  wire logic [15:0] enc_word_page,
   input  wire logic [15:0] enc_word_cause,
   // track c/d amplitude samples
   input  wire logic        cd_valid,
   input  wire logic [15:0] cd_level_c,
   input  wire logic [15:0] cd_level_d,
   // alarm outputs
   output logic             missing_zero_mark_alarm,
   output logic             evaluation_overtemp_fault,
   output logic             serial_comm_error_alarm,
   output logic             detailed_internal_alarm,
   output logic             plain_internal_alarm,
   output logic             cd_level_alarm,
   output logic             cd_start_valid
);

   // ----------------------------------------------------------------
   // ahb-lite address phase capture
   // ----------------------------------------------------------------
   logic        acc_ff;      // data phase pending
   logic        wr_ff;       // pending access is a write
   logic [7:0]  adr_ff;      // pending byte offset
   wire         addr_take = hsel & hready & htrans[1];
   wire         wr_go     = acc_ff & wr_ff;
   wire         rd_go     = acc_ff & ~wr_ff;

   // zero-wait slave, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // address phase register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= 1'b0;
         wr_ff  <= 1'b0;
         adr_ff <= 8'h00;
      end else if (hready) begin
         acc_ff <= addr_take;
         wr_ff  <= hwrite;
         adr_ff <= haddr[7:0];
      end
   end

   // register write strobes
   wire wr_ctrl   = wr_go & (adr_ff == enc_mon_pkg::ctrl_off);
   wire wr_rotary = wr_go & (adr_ff == enc_mon_pkg::rotary_off);
   wire wr_linear = wr_go & (adr_ff == enc_mon_pkg::linear_off);
   // read strobes that clear sticky words
   wire rd_serial = rd_go & (adr_ff == enc_mon_pkg::serial_off);
   wire rd_detail = rd_go & (adr_ff == enc_mon_pkg::detail_off);
   wire rd_plain  = rd_go & (adr_ff == enc_mon_pkg::plain_off);

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   logic        linear_ff;       // encoder type
   logic [31:0] rot_space_ff;    // rotary_mark_spacing_setting (increments)
   logic [31:0] lin_space_ff;    // linear_mark_spacing_setting (increments)

   // config registers written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         linear_ff    <= 1'b0;
         rot_space_ff <= enc_mon_pkg::spacing_rst;
         lin_space_ff <= enc_mon_pkg::spacing_rst;
      end else begin
         if (wr_ctrl)   linear_ff    <= hwdata[enc_mon_pkg::ctrl_linear_bit];
         if (wr_rotary) rot_space_ff <= hwdata;
         if (wr_linear) lin_space_ff <= hwdata;
      end
   end

   // ----------------------------------------------------------------
   // zero-mark monitor
   // ----------------------------------------------------------------
   wire [31:0] spacing  = linear_ff ? lin_space_ff : rot_space_ff;          // RL3
   wire [33:0] limit    = {2'b00, spacing} + {3'b000, spacing[31:1]};         // RL1
   logic [31:0] travel_ff;   // unsigned increments since mark
   logic [31:0] pos_ff;      // signed increments since mark
   wire [33:0] nxt_travel = {2'b00, travel_ff} + 34'd1;

   // counts every quadrature edge, four per pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         travel_ff <= 32'h0000_0000;                                       // RL22
         pos_ff    <= 32'h0000_0000;
         missing_zero_mark_alarm <= 1'b0;
      end else if (zero_mark) begin
         travel_ff <= 32'h0000_0000;                                       // RL22
         pos_ff    <= 32'h0000_0000;
         missing_zero_mark_alarm <= 1'b0;
      end else if (inc_step) begin
         // saturate so a stuck encoder never wraps back under the limit
         if (travel_ff != 32'hffff_ffff) travel_ff <= nxt_travel[31:0];    // RL2
         pos_ff <= inc_dir_neg ? pos_ff - 32'd1 : pos_ff + 32'd1;          // RL21
         if (nxt_travel > limit) missing_zero_mark_alarm <= 1'b1;          // RL1
      end
   end

   // ----------------------------------------------------------------
   // temperature
   // ----------------------------------------------------------------
   logic [15:0] temp_ff;   // last sample in 0.1 degc

   // fault latches once set; cleared only by reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         temp_ff <= 16'h0000;
         evaluation_overtemp_fault <= 1'b0;
      end else if (temp_valid) begin
         temp_ff <= temp_value;                                            // RL5
         if (temp_value > enc_mon_pkg::temp_limit)
            evaluation_overtemp_fault <= 1'b1;                            // RL4
      end
   end

   // ----------------------------------------------------------------
   // serial protocol
   // ----------------------------------------------------------------
   logic [22:0] wait_ff;     // cycles since request without start bit
   logic        waiting_ff;
   logic [7:0]  flen_ff;     // bits in current frame
   logic [15:0] ser_ff;      // sticky error word
   wire nostart = waiting_ff & (wait_ff == 23'(start_timeout_cyc - 1));
   wire toolong = ser_bit_strobe & (flen_ff == 8'(enc_mon_pkg::frame_max_len));
   logic [15:0] ser_set;

   // event bits into word positions
   always_comb begin
      ser_set = 16'h0000;
      ser_set[enc_mon_pkg::se_alarm_bit]   = ser_frame_alarm;              // RL6
      ser_set[enc_mon_pkg::se_idle_bit]    = ser_idle_err;                 // RL6
      ser_set[enc_mon_pkg::se_nostart_bit] = nostart;                      // RL7
      ser_set[enc_mon_pkg::se_crc_bit]     = ser_crc_err;                  // RL8
      ser_set[enc_mon_pkg::se_ack_bit]     = ser_ack_err;                  // RL9
      ser_set[enc_mon_pkg::se_mode_bit]    = ser_mode_err;                 // RL9
      ser_set[enc_mon_pkg::se_long_bit]    = toolong;                      // RL10
      ser_set[enc_mon_pkg::se_ovf_bit]     = ser_ovf_err;                  // RL11
      ser_set[enc_mon_pkg::se_dbl_bit]     = ser_dbl_err;                  // RL11
      ser_set[enc_mon_pkg::se_parity_bit]  = ser_parity_err;               // RL12
      ser_set[enc_mon_pkg::se_mono_bit]    = ser_mono_err;                 // RL12
   end

   // start-bit watchdog; one report per request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         waiting_ff <= 1'b0;
         wait_ff    <= 23'd0;
      end else if (ser_request) begin
         waiting_ff <= 1'b1;
         wait_ff    <= 23'd0;
      end else if (ser_start_bit || nostart) begin
         waiting_ff <= 1'b0;                                               // RL7
      end else if (waiting_ff) begin
         wait_ff <= wait_ff + 23'd1;
      end
   end

   // frame length counter saturates above the limit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flen_ff <= 8'd0;
      end else if (ser_frame_end || ser_start_bit) begin
         flen_ff <= 8'd0;
      end else if (ser_bit_strobe && flen_ff != 8'hff) begin
         flen_ff <= flen_ff + 8'd1;
      end
   end

   // sticky word: a new event beats the read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ser_ff <= 16'h0000;
      else          ser_ff <= (rd_serial ? 16'h0000 : ser_ff) | ser_set;   // RL23
   end
   assign serial_comm_error_alarm = |ser_ff;

   // ----------------------------------------------------------------
   // encoder internal alarms
   // ----------------------------------------------------------------
   logic [31:0] detail_ff;   // page in upper half, causes in lower
   logic [1:0]  plain_ff;    // fault, alarm bits of the position frame
   // pages zero and one keep only their documented cause bits; other pages keep all 16
   wire [15:0] cause_mask = (enc_word_page == 16'h0000) ? 16'h001f :      // RL14
                            (enc_word_page == 16'h0001) ? 16'h00ff :      // RL15
                                                          16'hffff;
   wire [15:0] cause_in   = enc_word_cause & cause_mask;

   // detail word latches newest page, keeps its causes until read or a page change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         detail_ff <= 32'h0000_0000;
      end else if (enc_word_valid && cause_in != 16'h0000) begin
         // a page change drops the old page's causes; same page accumulates
         if (enc_word_page != detail_ff[31:16] || rd_detail)
            detail_ff <= {enc_word_page, cause_in};                        // RL13
         else
            detail_ff <= {enc_word_page, detail_ff[15:0] | cause_in};
      end else if (rd_detail) begin
         detail_ff <= 32'h0000_0000;
      end
   end
   assign detailed_internal_alarm = |detail_ff[15:0];

   // plain word, set wins over read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) plain_ff <= 2'b00;
      else plain_ff <= (rd_plain ? 2'b00 : plain_ff)
                       | {ser_frame_alarm, ser_frame_fault};              // RL16
   end
   assign plain_internal_alarm = |plain_ff;

   // ----------------------------------------------------------------
   // track c/d level
   // ----------------------------------------------------------------
   logic [31:0] cd_ff;       // d upper, c lower
   wire [15:0] abs_c = cd_level_c[15] ? 16'(-cd_level_c) : cd_level_c;
   wire [15:0] abs_d = cd_level_d[15] ? 16'(-cd_level_d) : cd_level_d;
   wire c_bad = (abs_c < enc_mon_pkg::cd_low_code) |
                (abs_c > enc_mon_pkg::cd_high_code);                       // RL19
   wire d_bad = (abs_d < enc_mon_pkg::cd_low_code) |
                (abs_d > enc_mon_pkg::cd_high_code);
   wire cd_bad = c_bad | d_bad;

   // latest sample and band check
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cd_ff          <= 32'h0000_0000;
         cd_level_alarm <= 1'b0;
         cd_start_valid <= 1'b0;
      end else if (cd_valid) begin
         cd_ff          <= {cd_level_d, cd_level_c};                      // RL17
         cd_level_alarm <= cd_bad;                                        // RL18
         cd_start_valid <= ~cd_bad;                                       // RL20
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [31:0] status = {25'd0, cd_start_valid, cd_level_alarm, plain_internal_alarm,
                         detailed_internal_alarm, serial_comm_error_alarm,
                         evaluation_overtemp_fault, missing_zero_mark_alarm};
   logic [31:0] rd_word;

   always_comb begin
      unique case (adr_ff)
         enc_mon_pkg::ctrl_off:     rd_word = {31'd0, linear_ff};
         enc_mon_pkg::rotary_off:   rd_word = rot_space_ff;
         enc_mon_pkg::linear_off:   rd_word = lin_space_ff;
         enc_mon_pkg::status_off:   rd_word = status;
         enc_mon_pkg::zm_count_off: rd_word = pos_ff;                     // RL21
         enc_mon_pkg::temp_off:     rd_word = {16'd0, temp_ff};            // RL5
         enc_mon_pkg::serial_off:   rd_word = {16'd0, ser_ff};
         enc_mon_pkg::detail_off:   rd_word = detail_ff;
         enc_mon_pkg::plain_off:    rd_word = {30'd0, plain_ff};
         enc_mon_pkg::cd_off:       rd_word = cd_ff;
         default:                   rd_word = 32'h0000_0000;
      endcase
   end
   assign hrdata = rd_go ? rd_word : 32'h0000_0000;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_mark_clears: assert property (@(posedge hclk) disable iff (!hresetn) // RL22
      zero_mark |=> (travel_ff == 32'd0 && !missing_zero_mark_alarm))
      else $error("zero mark did not clear counter");
   a_missing_cause: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      $rose(missing_zero_mark_alarm) |-> $past(inc_step) && travel_ff > limit[31:0] - 1)
      else $error("missing mark alarm without excess travel");
   a_temp_fault: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      temp_valid && temp_value > 16'd1250 |=> evaluation_overtemp_fault)
      else $error("overtemp not raised");
   a_temp_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      $rose(evaluation_overtemp_fault) |-> $past(temp_value) > 16'd1250)
      else $error("overtemp raised below limit");
   a_crc_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      ser_crc_err |=> ser_ff[3] ##1 (ser_ff[3] || $past(rd_serial)))
      else $error("crc bit lost");
   a_nostart_time: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
      $rose(ser_ff[2]) |-> $past(wait_ff) == 23'(start_timeout_cyc - 1))
      else $error("start timeout at wrong time");
   a_long_frame: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      ser_bit_strobe && flen_ff == 8'd64 |=> ser_ff[8])
      else $error("long frame not flagged");
   a_cd_band: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
      cd_valid && cd_level_c == 16'h5333 && cd_level_d == 16'haccd |=> !cd_level_alarm)
      else $error("nominal level flagged");
   a_cd_start: assert property (@(posedge hclk) disable iff (!hresetn) // RL20
      cd_start_valid |-> !cd_level_alarm)
      else $error("out of band level usable for start");
   a_plain_bits: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
      ser_frame_fault |=> plain_ff[0])
      else $error("plain fault bit missing");

   c_missing: cover property (@(posedge hclk) $rose(missing_zero_mark_alarm));
   c_nostart: cover property (@(posedge hclk) $rose(ser_ff[2]));
   c_cd_low:  cover property (@(posedge hclk) $rose(cd_level_alarm));
   c_read_clr: cover property (@(posedge hclk) rd_serial && ser_ff != 16'h0);

endmodule

/* testbench/enc_model.sv */
// encoder front-end model: turns the bench's one-hot event select into strobes
// assumes the bench raises one select bit for exactly one hclk cycle
`timescale 1ns/1ps
module enc_model (
   // event select from the bench
   input  wire logic [13:0] ev,
   // strobes towards the monitor
   output logic      [13:0] st
);
   // ----------------------------------------------------------------
   // strobe pass-through
   // ----------------------------------------------------------------
   // no added latency, so the bench owns the exact pulse timing
   assign st = ev;
endmodule

/* testbench/encoder_alarm_monitor_tb_top.sv */
// self-checking bench for the encoder alarm monitor over ahb-lite
// assumes zero-wait slave and a short start timeout parameter
`timescale 1ns/1ps
module encoder_alarm_monitor_tb_top;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, inc_step = 0, inc_dir_neg = 0;
   logic        zero_mark = 0, temp_valid = 0, enc_word_valid = 0, cd_valid = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [15:0] temp_value = 0, enc_word_page = 0, enc_word_cause = 0;
   logic [15:0] cd_level_c = 0, cd_level_d = 0;
   logic [13:0] ev = 0, st;
   logic        hreadyout, hresp;
   logic [6:0]  al;  // status order, bit0 missing mark
   int          num_errors = 0, total_checks = 0, cyc = 0;
   int          sk[9] = '{0, 1, 3, 4, 5, 9, 10, 11, 12};
   logic [15:0] cv[5] = '{16'h2645, 16'h2644, 16'h7ccc, 16'h7ccd, 16'h5333};
   always #4 hclk = ~hclk;
   enc_model u_enc_model (.ev, .st);
   encoder_alarm_monitor #(.start_timeout_cyc(200)) u_encoder_alarm_monitor (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .inc_step, .inc_dir_neg,
      .zero_mark, .temp_valid, .temp_value, .ser_request(st[2]), .ser_start_bit(st[6]),
      .ser_frame_alarm(st[0]), .ser_frame_fault(st[7]), .ser_idle_err(st[1]),
      .ser_crc_err(st[3]), .ser_ack_err(st[4]), .ser_mode_err(st[5]),
      .ser_bit_strobe(st[8]), .ser_frame_end(st[13]), .ser_ovf_err(st[9]),
      .ser_dbl_err(st[10]), .ser_parity_err(st[11]), .ser_mono_err(st[12]),
      .enc_word_valid, .enc_word_page, .enc_word_cause, .cd_valid, .cd_level_c,
      .cd_level_d, .missing_zero_mark_alarm(al[0]), .evaluation_overtemp_fault(al[1]),
      .serial_comm_error_alarm(al[2]), .detailed_internal_alarm(al[3]),
      .plain_internal_alarm(al[4]), .cd_level_alarm(al[5]), .cd_start_valid(al[6]));
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, far above the sum of all scenarios
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // bus and stimulus tasks
   // ----------------------------------------------------------------
   // address phase held until hready, data phase likewise
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      bus(1, a, d, r);
   endtask
   task automatic rd(string n, logic [7:0] a, logic [31:0] e);
      logic [31:0] r;
      bus(0, a, 0, r);
      chk(n, r, e);
      chk("hresp", hresp, 0);
   endtask
   task automatic pulse(int k);
      @(posedge hclk); ev <= 14'h1 << k;
      @(posedge hclk); ev <= 0;
   endtask
   task automatic step(int n, logic neg);
      repeat (n) begin
         @(posedge hclk); inc_step <= 1; inc_dir_neg <= neg;
         @(posedge hclk); inc_step <= 0;
      end
   endtask
   task automatic mark();
      @(posedge hclk); zero_mark <= 1;
      @(posedge hclk); zero_mark <= 0;
   endtask
   task automatic sample(logic [2:0] v, logic [15:0] a, logic [15:0] b);
      @(posedge hclk);
      {cd_valid, enc_word_valid, temp_valid} <= v;
      {cd_level_d, enc_word_page, temp_value} <= {a, a, a};
      {cd_level_c, enc_word_cause} <= {b, b};
      @(posedge hclk); {cd_valid, enc_word_valid, temp_valid} <= 0;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_zero();
      rd("reset_spacing", enc_mon_pkg::rotary_off, 32'h0000_0800);
      rd("status_rst", enc_mon_pkg::status_off, 0);
      wr(enc_mon_pkg::rotary_off, 8);
      step(12, 0);
      rd("no_alarm_at_limit", enc_mon_pkg::status_off, 0);
      step(1, 0);
      rd("alarm_past_limit", enc_mon_pkg::status_off, 1);
      rd("incr_count", enc_mon_pkg::zm_count_off, 13);
      mark();
      rd("count_cleared", enc_mon_pkg::zm_count_off, 0);
      step(3, 1);
      rd("neg_count", enc_mon_pkg::zm_count_off, 32'hffff_fffd);
      wr(enc_mon_pkg::ctrl_off, 1);
      wr(enc_mon_pkg::linear_off, 4);
      mark();
      step(6, 0);
      // the last step lands on the edge the task returns at, so wait one more
      @(posedge hclk);
      chk("lin_no_alarm", al[0], 0);
      step(1, 0);
      @(posedge hclk);
      chk("lin_alarm", al[0], 1);
      mark();
   endtask
   task automatic t_serial();
      foreach (sk[i]) begin
         pulse(sk[i]);
         repeat (3) @(posedge hclk);
         chk("ser_held", al[2], 1);
         rd("ser_word", enc_mon_pkg::serial_off, 32'h1 << sk[i]);
      end
      rd("ser_cleared", enc_mon_pkg::serial_off, 0);
      pulse(2); pulse(6);
      repeat (210) @(posedge hclk);
      rd("start_seen", enc_mon_pkg::serial_off, 0);
      pulse(2);
      repeat (210) @(posedge hclk);
      rd("no_start", enc_mon_pkg::serial_off, 32'h4);
      repeat (64) pulse(8);
      pulse(13);
      rd("len_64", enc_mon_pkg::serial_off, 0);
      repeat (65) pulse(8);
      pulse(13);
      rd("len_65", enc_mon_pkg::serial_off, 32'h100);
   endtask
   task automatic t_misc();
      sample(3'b001, 16'd1250, 0);
      // plain alarm still held from the frame alarm of the serial scenario
      rd("temp_at_limit", enc_mon_pkg::status_off, 32'h10);
      sample(3'b001, 16'd1251, 0);
      rd("temp_value", enc_mon_pkg::temp_off, 1251);
      chk("overtemp", al[1], 1);
      sample(3'b010, 16'h1, 16'hffff);
      @(posedge hclk);
      chk("detail_al", al[3], 1);
      rd("detail_p1", enc_mon_pkg::detail_off, 32'h0001_00ff);
      sample(3'b010, 16'h0, 16'hffff);
      rd("detail_p0", enc_mon_pkg::detail_off, 32'h0000_001f);
      pulse(7);
      rd("plain", enc_mon_pkg::plain_off, 32'h3);
      foreach (cv[i]) begin
         sample(3'b100, 16'h0 - cv[i], cv[i]);
         repeat (2) @(posedge hclk);
         chk("cd_alarm", al[5], i % 2);
         chk("cd_start", al[6], 1 - i % 2);
         rd("cd_word", enc_mon_pkg::cd_off, {16'h0 - cv[i], cv[i]});
      end
      rd("unmapped", 8'h30, 0);
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      t_zero();
      t_serial();
      t_misc();
      summarize();
   end
endmodule
